// ===== logic/rxm_defines.svh
// constants for the receiver error interrupt mask block
// assumes a byte-wide control port with 7-bit register addresses
// Functional notes
// R1: mask bit 6 lets the emphasis flag interrupt when one.
// R2: mask bit 5 lets the non-audio payload flag interrupt when one.
// R3: mask bit 4 lets the non-audio preamble-type flag interrupt when one.
// R4: mask bit 3 lets the checksum fault flag interrupt when one.
// R5: mask bit 2 lets the input-absent flag interrupt when one.
// R6: mask bit 1 lets the biphase or parity fault flag interrupt when one.
// R7: mask bit 0 lets the lock flag interrupt when one.
// R8: mask bit 7 lets the received validity flag interrupt when one.
// R9: checksum fault flag stays set until the error status register is read.
// R10: input-absent flag follows the stream; after a read only changes interrupt.
`ifndef RXM_DEFINES_SVH
`define RXM_DEFINES_SVH

`define RXM_ADDR_W        7
`define RXM_STATUS_ADDR   7'h18
`define RXM_MASK_ADDR     7'h19
`define RXM_MASK_RESET    8'h00

`define RXM_BIT_VALID     7
`define RXM_BIT_EMPH      6
`define RXM_BIT_NONAUDIO  5
`define RXM_BIT_PREAMBLE  4
`define RXM_BIT_CHECKSUM  3
`define RXM_BIT_ABSENT    2
`define RXM_BIT_BIPHASE   1
`define RXM_BIT_LOCK      0

// bits that latch until read; the rest are levels reported on change
`define RXM_STICKY_BITS   8'h0A

`endif

// ===== logic/rxm_pkg.sv
// types for the receiver error interrupt mask block
// assumes rxm_defines.svh supplies all numeric constants
package rxm_pkg;

	typedef logic [7:0] rxm_byte_t;

endpackage : rxm_pkg

// ===== logic/rxm_top.sv
// receiver error status, interrupt mask and interrupt request
// assumes a synchronous byte-wide control port and flags sampled on REF_CLK
`timescale 1ns/1ps
`include "rxm_defines.svh"

// one receiver flag: change or fault capture, read clear, mask gate
module rxm_flag_cell
	import rxm_pkg::*;
#(
	parameter bit STICKY = 1'b0
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic flag_in,
	input  wire logic clear,
	input  wire logic gate,
	output      logic view,
	output      logic req
);

	logic level_q;
	logic hold_q;

	// previous level for change detection
	always_ff @(posedge clk)
	begin
		if (rst)
			level_q <= 1'b0;
		else
			level_q <= flag_in;
	end

	// held event; a new event wins over the read clear
	always_ff @(posedge clk)
	begin
		if (rst)
			hold_q <= 1'b0;
		else if (STICKY)
			hold_q <= (hold_q & ~clear) | flag_in; // [R9]
		else
			hold_q <= (hold_q & ~clear) | (flag_in ^ level_q); // [R10]
	end

	// faults shown latched, levels shown live
	assign view = STICKY ? hold_q : flag_in;

	// mask gate on the held event
	assign req  = hold_q & gate;

endmodule : rxm_flag_cell

module rxm_top
	import rxm_pkg::*;
(
	input  wire logic                   REF_CLK,
	input  wire logic                   RST,
	input  wire logic [`RXM_ADDR_W-1:0] REG_ADDR,
	input  wire logic                   REG_WR,
	input  wire logic                   REG_RD,
	input  wire logic [7:0]             REG_WDATA,
	output      logic [7:0]             REG_RDATA,
	input  wire logic [7:0]             RX_FLAGS,
	output      logic                   RX_ERR_IRQ
);

	localparam rxm_byte_t sticky_m = `RXM_STICKY_BITS;

	rxm_byte_t mask_q;
	rxm_byte_t status_view;
	rxm_byte_t gated_req;
	logic      mask_wr;
	logic      status_rd;

	assign mask_wr   = REG_WR && (REG_ADDR == `RXM_MASK_ADDR);
	assign status_rd = REG_RD && (REG_ADDR == `RXM_STATUS_ADDR);

	// mask register
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			mask_q <= `RXM_MASK_RESET;
		else if (mask_wr)
			mask_q <= REG_WDATA;
	end

	// received validity flag
	rxm_flag_cell #(
		.STICKY (sticky_m[`RXM_BIT_VALID])
	) u_rxm_flag_cell_valid (
		.clk     (REF_CLK),
		.rst     (RST),
		.flag_in (RX_FLAGS[`RXM_BIT_VALID]),
		.clear   (status_rd),
		.gate    (mask_q[`RXM_BIT_VALID]), // [R8]
		.view    (status_view[`RXM_BIT_VALID]),
		.req     (gated_req[`RXM_BIT_VALID])
	);

	// emphasis flag
	rxm_flag_cell #(
		.STICKY (sticky_m[`RXM_BIT_EMPH])
	) u_rxm_flag_cell_emph (
		.clk     (REF_CLK),
		.rst     (RST),
		.flag_in (RX_FLAGS[`RXM_BIT_EMPH]),
		.clear   (status_rd),
		.gate    (mask_q[`RXM_BIT_EMPH]), // [R1]
		.view    (status_view[`RXM_BIT_EMPH]),
		.req     (gated_req[`RXM_BIT_EMPH])
	);

	// non-audio payload flag
	rxm_flag_cell #(
		.STICKY (sticky_m[`RXM_BIT_NONAUDIO])
	) u_rxm_flag_cell_nonaudio (
		.clk     (REF_CLK),
		.rst     (RST),
		.flag_in (RX_FLAGS[`RXM_BIT_NONAUDIO]),
		.clear   (status_rd),
		.gate    (mask_q[`RXM_BIT_NONAUDIO]), // [R2]
		.view    (status_view[`RXM_BIT_NONAUDIO]),
		.req     (gated_req[`RXM_BIT_NONAUDIO])
	);

	// non-audio preamble-type flag
	rxm_flag_cell #(
		.STICKY (sticky_m[`RXM_BIT_PREAMBLE])
	) u_rxm_flag_cell_preamble (
		.clk     (REF_CLK),
		.rst     (RST),
		.flag_in (RX_FLAGS[`RXM_BIT_PREAMBLE]),
		.clear   (status_rd),
		.gate    (mask_q[`RXM_BIT_PREAMBLE]), // [R3]
		.view    (status_view[`RXM_BIT_PREAMBLE]),
		.req     (gated_req[`RXM_BIT_PREAMBLE])
	);

	// channel-status checksum fault, latched until read
	rxm_flag_cell #(
		.STICKY (sticky_m[`RXM_BIT_CHECKSUM])
	) u_rxm_flag_cell_checksum (
		.clk     (REF_CLK),
		.rst     (RST),
		.flag_in (RX_FLAGS[`RXM_BIT_CHECKSUM]),
		.clear   (status_rd),
		.gate    (mask_q[`RXM_BIT_CHECKSUM]), // [R4]
		.view    (status_view[`RXM_BIT_CHECKSUM]),
		.req     (gated_req[`RXM_BIT_CHECKSUM])
	);

	// input-absent flag
	rxm_flag_cell #(
		.STICKY (sticky_m[`RXM_BIT_ABSENT])
	) u_rxm_flag_cell_absent (
		.clk     (REF_CLK),
		.rst     (RST),
		.flag_in (RX_FLAGS[`RXM_BIT_ABSENT]),
		.clear   (status_rd),
		.gate    (mask_q[`RXM_BIT_ABSENT]), // [R5]
		.view    (status_view[`RXM_BIT_ABSENT]),
		.req     (gated_req[`RXM_BIT_ABSENT])
	);

	// biphase or parity fault, latched until read
	rxm_flag_cell #(
		.STICKY (sticky_m[`RXM_BIT_BIPHASE])
	) u_rxm_flag_cell_biphase (
		.clk     (REF_CLK),
		.rst     (RST),
		.flag_in (RX_FLAGS[`RXM_BIT_BIPHASE]),
		.clear   (status_rd),
		.gate    (mask_q[`RXM_BIT_BIPHASE]), // [R6]
		.view    (status_view[`RXM_BIT_BIPHASE]),
		.req     (gated_req[`RXM_BIT_BIPHASE])
	);

	// receiver lock flag
	rxm_flag_cell #(
		.STICKY (sticky_m[`RXM_BIT_LOCK])
	) u_rxm_flag_cell_lock (
		.clk     (REF_CLK),
		.rst     (RST),
		.flag_in (RX_FLAGS[`RXM_BIT_LOCK]),
		.clear   (status_rd),
		.gate    (mask_q[`RXM_BIT_LOCK]), // [R7]
		.view    (status_view[`RXM_BIT_LOCK]),
		.req     (gated_req[`RXM_BIT_LOCK])
	);

	// gated interrupt request
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			RX_ERR_IRQ <= 1'b0;
		else
			RX_ERR_IRQ <= |gated_req;
	end

	// read data, one cycle after the strobe
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			REG_RDATA <= 8'h00;
		else if (REG_RD)
		begin
			case (REG_ADDR)
				`RXM_STATUS_ADDR: REG_RDATA <= status_view;
				`RXM_MASK_ADDR:   REG_RDATA <= mask_q;
				default:          REG_RDATA <= 8'h00;
			endcase
		end
	end

endmodule : rxm_top

// ===== tb/rxm_top_assertions.sv
// checker on rxm_top ports
// assumes mask at 0x19, irq within 3 edges
`timescale 1ns/1ps
module rxm_top_chk
(
	input wire logic       REF_CLK,
	input wire logic       RST,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [6:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] RX_FLAGS,
	input wire logic       RX_ERR_IRQ
);
	logic [7:0] m_q;
	wire [7:0] f = RX_FLAGS;
	wire q = RX_ERR_IRQ;
	wire [7:0] g = m_q & {8{!(REG_WR | REG_RD)}};
	always_ff @(posedge REF_CLK)
		if (RST) m_q <= 8'h00;
		else if (REG_WR && REG_ADDR == 7'h19) m_q <= REG_WDATA;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	a_valid_gate: assert property ($changed(f[7]) ##1 g[7] |-> ##[1:2] q)
		else $error("irq");
	a_emph_gate: assert property ($changed(f[6]) ##1 g[6] |-> ##[1:2] q)
		else $error("irq");
	a_pay_gate: assert property ($changed(f[5]) ##1 g[5] |-> ##[1:2] q)
		else $error("irq");
	a_pre_gate: assert property ($changed(f[4]) ##1 g[4] |-> ##[1:2] q)
		else $error("irq");
	a_sum_latch: assert property (f[3] ##1 g[3] |-> ##[1:2] q)
		else $error("irq");
	a_absent_gate: assert property ($changed(f[2]) ##1 g[2] |-> ##[1:2] q)
		else $error("irq");
	a_par_latch: assert property (f[1] ##1 g[1] |-> ##[1:2] q)
		else $error("irq");
	a_lock_gate: assert property ($changed(f[0]) ##1 g[0] |-> ##[1:2] q)
		else $error("irq");
	a_mask_quiet: assert property ((m_q == 8'h00) |=> !q)
		else $error("irq with all gates closed");
endmodule : rxm_top_chk
bind rxm_top rxm_top_chk u_rxm_top_chk (.REF_CLK(REF_CLK), .RST(RST),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .RX_FLAGS(RX_FLAGS), .RX_ERR_IRQ(RX_ERR_IRQ));

// ===== tb/rxm_top_tb.sv
// bench for rxm_top
// assumes flags idle low
`timescale 1ns/1ps
module rxm_top_tb;
	logic clk = 0, rst = 1, w = 0, r = 0, z, e;
	logic [6:0] a = 0;
	logic [7:0] d = 0, f = 0, q, m, p = 0;
	logic [31:0] s = 32'h49bf;
	int n_mismatch = 0, check_count = 0, i;
	rxm_top u_rxm_top (.REF_CLK(clk), .RST(rst), .REG_ADDR(a), .REG_WR(w),
		.REG_RD(r), .REG_WDATA(d), .REG_RDATA(q), .RX_FLAGS(f), .RX_ERR_IRQ(z));
	function logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx
	task ck(input string n, input logic [7:0] x, y);
		check_count++;
		if (x !== y)
		begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", n, x, y);
		end
	endtask : ck
	task op(input logic v, input logic [6:0] b, input logic [7:0] c);
		@(posedge clk);
		{a, d, w, r} <= {b, c, v, !v};
		@(posedge clk);
		{w, r} <= 2'b00;
		@(posedge clk);
	endtask : op
	task stop_test;
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	initial forever #5 clk = ~clk;
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 0;
		op(0, 7'h19, 0);
		ck("mask", 8'h00, q);
		op(0, 7'h7f, 0);
		ck("hole", 8'h00, q);
		for (i = 0; i < 16; i++)
		begin
			s = nx(s);
			m = s[7:0] ^ ((s[7:0] ^ {8{i[3]}}) & 8'h01 << i[2:0]);
			op(0, 7'h18, 0);
			ck("stat", p, q);
			op(1, 7'h19, m);
			op(0, 7'h19, 0);
			ck("mask", m, q);
			f <= 8'h01 << i[2:0];
			p = 8'h0a & 8'h01 << i[2:0];
			@(posedge clk);
			f <= 0;
			e = 0;
			repeat (6) @(negedge clk) e |= z;
			ck("irq", i[3], e);
		end
		op(1, 7'h19, 8'h04);
		op(0, 7'h18, 0);
		f <= 8'h04;
		e = 0;
		repeat (6) @(negedge clk) e |= z;
		ck("absent irq", 8'h01, e);
		op(0, 7'h18, 0);
		ck("absent stat", 8'h04, q);
		e = 0;
		repeat (6) @(negedge clk) e |= z;
		ck("absent hold", 8'h00, e);
		@(posedge clk);
		f <= 0;
		e = 0;
		repeat (6) @(negedge clk) e |= z;
		ck("absent change", 8'h01, e);
		stop_test();
	end
endmodule : rxm_top_tb
